// ---- hdl/mcuiv_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by every file that needs a constant of the block.
// Notes:   Definitions only.
`ifndef MCUIV_MAP_SVH
`define MCUIV_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Wishbone slave
// ----------------------------------------------------------------------
`define MCUIV_OFS_IRQ_ENABLE   5'h00
`define MCUIV_OFS_KERNEL_EN    5'h04
`define MCUIV_OFS_PRIO         5'h08
`define MCUIV_OFS_KERNEL_PRIO  5'h0c
`define MCUIV_OFS_USB_CTRL     5'h10
`define MCUIV_OFS_STATUS       5'h14
`define MCUIV_OFS_LAST_VEC     5'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCUIV_BIT_TIMER0       1
`define MCUIV_BIT_TIMER1       3
`define MCUIV_BIT_SERIAL       4
`define MCUIV_BIT_INTERNAL     5
`define MCUIV_BIT_GLOBAL       7
`define MCUIV_BIT_KERNEL       0
`define MCUIV_BIT_FRC          0
`define MCUIV_IRQ_ENABLE_MASK  8'hba
`define MCUIV_PRIO_MASK        8'h3a
`define MCUIV_BIT0_MASK        8'h01
`define MCUIV_REG_RESET        8'h00

// ----------------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------------
`define MCUIV_VEC_RESET        16'h2000
`define MCUIV_VEC_TIMER0       16'h200b
`define MCUIV_VEC_TIMER1       16'h201b
`define MCUIV_VEC_SERIAL       16'h2023
`define MCUIV_VEC_INTERNAL     16'h202b
`define MCUIV_VEC_KERNEL       16'h2033

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MCUIV_INTERNAL_INSTRS  8
`define MCUIV_CLKS_PER_INSTR   4
`define MCUIV_INTERNAL_CLKS    (`MCUIV_INTERNAL_INSTRS * `MCUIV_CLKS_PER_INSTR)

`endif

// ---- hdl/mcuiv_pkg.sv ----
// Purpose: Types shared by the vectoring logic.
// Assumes: Nothing.
// Notes:   Constants live in mcuiv_map.svh.
`default_nettype none
package mcuiv_pkg;

    typedef enum logic [2:0] {
        MCUIV_SRC_TIMER0,
        MCUIV_SRC_TIMER1,
        MCUIV_SRC_SERIAL,
        MCUIV_SRC_INTERNAL,
        MCUIV_SRC_KERNEL
    } mcuiv_src_t;

    typedef enum logic [2:0] {
        MCUIV_ST_BOOT,
        MCUIV_ST_IDLE,
        MCUIV_ST_REQ,
        MCUIV_ST_DELAY,
        MCUIV_ST_JUMP
    } mcuiv_state_t;

endpackage
`default_nettype wire

// ---- hdl/mcuiv_prio.sv ----
// Purpose: Picks the request to service among the enabled pending ones.
// Assumes: pend already holds only enabled requests.
// Notes:   High-priority level first, then fixed source order.
`timescale 1ns/1ps
`default_nettype none
module mcuiv_prio
    import mcuiv_pkg::*;
(
    mcuiv_sel_if.sel sel
);

    // ------------------------------------------------------------------
    // Two-level fixed priority
    // ------------------------------------------------------------------
    // Lower source index wins within a level, so timer-0 beats the kernel.
    logic [4:0] hi_pend;
    logic [4:0] use_pend;

    always_comb begin
        hi_pend    = sel.pend & sel.high;
        use_pend   = (hi_pend != 5'h00) ? hi_pend : sel.pend;
        sel.valid  = (sel.pend != 5'h00);
        sel.winner = MCUIV_SRC_TIMER0;
        for (int i = 4; i >= 0; i--) begin
            if (use_pend[i]) begin
                sel.winner = mcuiv_src_t'(i[2:0]);
            end
        end
    end

endmodule
`default_nettype wire

// ---- hdl/mcuiv_sel_if.sv ----
// Purpose: Carries enabled pending and priority vectors to the selector.
// Assumes: One clock domain.
// Notes:   The answer is combinational.
`timescale 1ns/1ps
`default_nettype none
interface mcuiv_sel_if;
    import mcuiv_pkg::*;
    logic       [4:0] pend;
    logic       [4:0] high;
    logic             valid;
    mcuiv_src_t       winner;
    modport ctl (output pend, output high, input valid, input winner);
    modport sel (input pend, input high, output valid, output winner);
endinterface
`default_nettype wire

// ---- hdl/mcuiv_top.sv ----
// Purpose: Interrupt collection and vector relocation for the embedded
//          microcontroller, with registers on a classic Wishbone slave.
// Assumes: Event sources and core run on clk_i; sources are levels.
// Notes:   rst_i is the power-up reset.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mcuiv_map.svh"
module mcuiv_top
    import mcuiv_pkg::*;
#(
    parameter int N_INTERNAL = 8
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave.
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [4:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    // Event sources.
    input  wire logic                  timer0_irq_i,
    input  wire logic                  timer1_irq_i,
    input  wire logic                  serial_irq_i,
    input  wire logic [N_INTERNAL-1:0] internal_src_i,
    input  wire logic                  real_time_kernel_irq_i,
    // Reset causes besides rst_i, and the end of the boot download.
    input  wire logic                  watchdog_timer_reset_i,
    input  wire logic                  usb_bus_reset_i,
    input  wire logic                  download_done_i,
    // Core side.
    output logic                       core_irq_req_o,
    input  wire logic                  core_irq_ack_i,
    output logic                       core_jump_o,
    output logic      [15:0]           core_jump_addr_o,
    output logic                       app_mode_o
);

    // ------------------------------------------------------------------
    // Reset causes
    // ------------------------------------------------------------------
    logic hard_clr;
    logic irq_clr;
    logic [7:0] usb_control_reg_ff;

    assign hard_clr = rst_i | watchdog_timer_reset_i;
    // A USB bus reset only reaches the interrupt registers when connected.
    assign irq_clr  = hard_clr | (usb_bus_reset_i
                    & usb_control_reg_ff[`MCUIV_BIT_FRC]);

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic       wb_hit;
    logic       wr_en;
    logic [7:0] irq_enable_reg_ff;
    logic [7:0] kernel_en_reg_ff;
    logic [7:0] prio_reg_ff;
    logic [7:0] kernel_prio_reg_ff;
    logic [4:0] pend_ff;
    logic [15:0] last_vec_ff;
    mcuiv_state_t state_ff;
    mcuiv_state_t nxt_state;

    assign wb_hit = cyc_i & stb_i & ~ack_o;
    assign wr_en  = wb_hit & we_i & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_hit & ~we_i) begin
            case (adr_i)
                `MCUIV_OFS_IRQ_ENABLE:  dat_o <= {24'h000000,
                                                  irq_enable_reg_ff};
                `MCUIV_OFS_KERNEL_EN:   dat_o <= {24'h000000,
                                                  kernel_en_reg_ff};
                `MCUIV_OFS_PRIO:        dat_o <= {24'h000000, prio_reg_ff};
                `MCUIV_OFS_KERNEL_PRIO: dat_o <= {24'h000000,
                                                  kernel_prio_reg_ff};
                `MCUIV_OFS_USB_CTRL:    dat_o <= {24'h000000,
                                                  usb_control_reg_ff};
                `MCUIV_OFS_STATUS:      dat_o <= {20'h00000, 1'b0,
                                                  state_ff, 3'h0,
                                                  pend_ff};
                `MCUIV_OFS_LAST_VEC:    dat_o <= {16'h0000, last_vec_ff};
                default:                dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt registers
    // ------------------------------------------------------------------
    // Reserved bits are masked on write, so they always read as zero.
    // The external-input enable positions are reserved here as well.
    always_ff @(posedge clk_i) begin
        if (irq_clr) begin
            irq_enable_reg_ff  <= `MCUIV_REG_RESET;
            kernel_en_reg_ff   <= `MCUIV_REG_RESET;
            prio_reg_ff        <= `MCUIV_REG_RESET;
            kernel_prio_reg_ff <= `MCUIV_REG_RESET;
        end else if (wr_en) begin
            case (adr_i)
                `MCUIV_OFS_IRQ_ENABLE:
                    irq_enable_reg_ff <= dat_i[7:0]
                                       & `MCUIV_IRQ_ENABLE_MASK;
                `MCUIV_OFS_KERNEL_EN:
                    kernel_en_reg_ff <= dat_i[7:0] & `MCUIV_BIT0_MASK;
                `MCUIV_OFS_PRIO:
                    prio_reg_ff <= dat_i[7:0] & `MCUIV_PRIO_MASK;
                `MCUIV_OFS_KERNEL_PRIO:
                    kernel_prio_reg_ff <= dat_i[7:0] & `MCUIV_BIT0_MASK;
                default: begin
                end
            endcase
        end
    end

    // The connect bit is not an interrupt register: USB reset spares it.
    always_ff @(posedge clk_i) begin
        if (hard_clr) begin
            usb_control_reg_ff <= `MCUIV_REG_RESET;
        end else if (wr_en && adr_i == `MCUIV_OFS_USB_CTRL) begin
            usb_control_reg_ff <= dat_i[7:0] & `MCUIV_BIT0_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Source enables and pending flags
    // ------------------------------------------------------------------
    logic       global_irq_enable;
    logic       internal_events_request;
    logic [4:0] raw_src;
    logic [4:0] src_en;
    logic [4:0] src_high;
    logic [4:0] clr_pend;
    mcuiv_src_t cur_src_ff;

    assign global_irq_enable = irq_enable_reg_ff[`MCUIV_BIT_GLOBAL];
    assign internal_events_request = |internal_src_i;

    assign raw_src = {real_time_kernel_irq_i, internal_events_request,
                      serial_irq_i, timer1_irq_i, timer0_irq_i};

    assign src_en = {kernel_en_reg_ff[`MCUIV_BIT_KERNEL],
                     irq_enable_reg_ff[`MCUIV_BIT_INTERNAL],
                     irq_enable_reg_ff[`MCUIV_BIT_SERIAL],
                     irq_enable_reg_ff[`MCUIV_BIT_TIMER1],
                     irq_enable_reg_ff[`MCUIV_BIT_TIMER0]};

    assign src_high = {kernel_prio_reg_ff[`MCUIV_BIT_KERNEL],
                       prio_reg_ff[`MCUIV_BIT_INTERNAL],
                       prio_reg_ff[`MCUIV_BIT_SERIAL],
                       prio_reg_ff[`MCUIV_BIT_TIMER1],
                       prio_reg_ff[`MCUIV_BIT_TIMER0]};

    // A pending flag drops in the cycle after the core acks its request.
    always_comb begin
        clr_pend = 5'h00;
        if (state_ff == MCUIV_ST_REQ && core_irq_ack_i) begin
            clr_pend[cur_src_ff] = 1'b1;
        end
    end

    // A source still active in the clearing cycle sets the flag again.
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_pend
            always_ff @(posedge clk_i) begin
                if (irq_clr) begin
                    pend_ff[g] <= 1'b0;
                end else if (raw_src[g]) begin
                    pend_ff[g] <= 1'b1;
                end else if (clr_pend[g]) begin
                    pend_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Priority selection
    // ------------------------------------------------------------------
    mcuiv_sel_if sel_bus ();

    assign sel_bus.pend = global_irq_enable ? (pend_ff & src_en)
                                            : 5'h00;
    assign sel_bus.high = src_high;

    mcuiv_prio mcuiv_prio_inst (
        .sel (sel_bus)
    );

    function automatic logic [15:0] vec_of(input mcuiv_src_t s);
        case (s)
            MCUIV_SRC_TIMER0:   vec_of = `MCUIV_VEC_TIMER0;
            MCUIV_SRC_TIMER1:   vec_of = `MCUIV_VEC_TIMER1;
            MCUIV_SRC_SERIAL:   vec_of = `MCUIV_VEC_SERIAL;
            MCUIV_SRC_INTERNAL: vec_of = `MCUIV_VEC_INTERNAL;
            MCUIV_SRC_KERNEL:   vec_of = `MCUIV_VEC_KERNEL;
            default:            vec_of = `MCUIV_VEC_RESET;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Dispatch sequence
    // ------------------------------------------------------------------
    logic [7:0] delay_cnt_ff;
    logic       boot_done_ff;
    logic       delay_done;

    assign delay_done = (delay_cnt_ff == 8'(`MCUIV_INTERNAL_CLKS - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MCUIV_ST_BOOT: begin
                if (download_done_i) begin
                    nxt_state = MCUIV_ST_JUMP;
                end
            end
            MCUIV_ST_IDLE: begin
                if (sel_bus.valid) begin
                    nxt_state = MCUIV_ST_REQ;
                end
            end
            MCUIV_ST_REQ: begin
                if (core_irq_ack_i) begin
                    nxt_state = (cur_src_ff == MCUIV_SRC_INTERNAL)
                              ? MCUIV_ST_DELAY : MCUIV_ST_JUMP;
                end else if (!sel_bus.valid) begin
                    nxt_state = MCUIV_ST_IDLE;
                end
            end
            MCUIV_ST_DELAY: begin
                if (delay_done) begin
                    nxt_state = MCUIV_ST_JUMP;
                end
            end
            MCUIV_ST_JUMP: begin
                nxt_state = MCUIV_ST_IDLE;
            end
            default: begin
                nxt_state = MCUIV_ST_IDLE;
            end
        endcase
    end

    // Only power-up and watchdog resets return to boot code.
    always_ff @(posedge clk_i) begin
        if (hard_clr) begin
            state_ff <= MCUIV_ST_BOOT;
        end else if (usb_bus_reset_i & usb_control_reg_ff[`MCUIV_BIT_FRC]
                     & boot_done_ff) begin
            state_ff <= MCUIV_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // The winner is re-chosen while waiting, so a higher request can
    // overtake until the core acknowledges.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_src_ff <= MCUIV_SRC_TIMER0;
        end else if (nxt_state == MCUIV_ST_REQ) begin
            cur_src_ff <= sel_bus.winner;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_cnt_ff <= 8'h00;
        end else if (state_ff == MCUIV_ST_DELAY) begin
            delay_cnt_ff <= delay_cnt_ff + 8'h01;
        end else begin
            delay_cnt_ff <= 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_clr) begin
            boot_done_ff <= 1'b0;
        end else if (state_ff == MCUIV_ST_JUMP) begin
            boot_done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_irq_req_o <= 1'b0;
        end else begin
            core_irq_req_o <= (nxt_state == MCUIV_ST_REQ) & ~irq_clr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_jump_o      <= 1'b0;
            core_jump_addr_o <= 16'h0000;
        end else if (nxt_state == MCUIV_ST_JUMP && !hard_clr) begin
            core_jump_o      <= 1'b1;
            core_jump_addr_o <= boot_done_ff ? vec_of(cur_src_ff)
                                             : `MCUIV_VEC_RESET;
        end else begin
            core_jump_o      <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (irq_clr) begin
            last_vec_ff <= 16'h0000;
        end else if (core_jump_o) begin
            last_vec_ff <= core_jump_addr_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_clr) begin
            app_mode_o <= 1'b0;
        end else begin
            app_mode_o <= boot_done_ff | (state_ff == MCUIV_ST_JUMP);
        end
    end

endmodule
`default_nettype wire

// ---- sim/mcuiv_core_model.sv ----
// Purpose: Core and firmware stand-in that acks requests after a wait.
// Assumes: One clock; the ack is a one-cycle pulse.
// Notes:   bad_o latches any jump outside the firmware vector table.
`timescale 1ns/1ps
`default_nettype none
module mcuiv_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        jump_i,
    input  wire logic [15:0] addr_i,
    output logic             ack_o,
    output logic             bad_o
);
    logic [3:0] cnt_ff;

    // Acks only while the request shows, so a late ack is never sent.
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i || ack_o) begin
            cnt_ff <= 4'h0;
            ack_o  <= 1'b0;
        end else if (cnt_ff >= wait_i) begin
            ack_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // The table starts at 0x2000; any other target lands in boot code.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_o <= 1'b0;
        end else if (jump_i && !(addr_i inside {16'h2000, 16'h200b,
                     16'h201b, 16'h2023, 16'h202b, 16'h2033})) begin
            bad_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- sim/mcuiv_props.sv ----
// Purpose: Concurrent checks on the vectoring block's top-level ports.
// Assumes: One clock domain; the core acks only while a request shows.
// Notes:   Bound to mcuiv_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module mcuiv_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        core_irq_req_o,
    input wire logic        core_irq_ack_i,
    input wire logic        core_jump_o,
    input wire logic [15:0] core_jump_addr_o,
    input wire logic        app_mode_o,
    input wire logic        watchdog_timer_reset_i
);
    logic [5:0] since_ack_ff;

    // Saturates so a long quiet spell cannot wrap into the delay window.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_ack_ff <= 6'h3f;
        end else if (core_irq_ack_i) begin
            since_ack_ff <= 6'h01;
        end else if (since_ack_ff != 6'h3f) begin
            since_ack_ff <= since_ack_ff + 6'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || watchdog_timer_reset_i);

    property p_ack_pulse;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack not a single cycle after request");
    property p_reset;
        disable iff (1'b0)
        rst_i |=> !core_irq_req_o && !core_jump_o && !app_mode_o && !ack_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
    property p_wdog;
        disable iff (rst_i)
        watchdog_timer_reset_i |=> !core_irq_req_o && !core_jump_o;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog reset left request or jump active");
    property p_vec_range;
        core_jump_o |-> core_jump_addr_o[15:8] == 8'h20;
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("jump target outside relocated range");
    property p_no_ext;
        core_jump_o |-> !(core_jump_addr_o inside {16'h2003, 16'h2013});
    endproperty
    a_no_ext: assert property (p_no_ext)
        else $error("jump to an absent external input vector");
    property p_int_delay;
        core_jump_o && core_jump_addr_o == 16'h202b
            |-> since_ack_ff inside {[6'd32:6'd34]};
    endproperty
    a_int_delay: assert property (p_int_delay)
        else $error("internal events jump without the boot delay");
    property p_fast_jump;
        core_jump_o && !(core_jump_addr_o inside {16'h202b, 16'h2000})
            |-> since_ack_ff == 6'h01;
    endproperty
    a_fast_jump: assert property (p_fast_jump)
        else $error("jump not in the cycle after the core ack");
    property p_req_ack;
        core_irq_req_o && core_irq_ack_i |=> !core_irq_req_o;
    endproperty
    a_req_ack: assert property (p_req_ack)
        else $error("request still shown after the core ack");
    property p_boot;
        $rose(app_mode_o) |-> (core_jump_o || $past(core_jump_o))
            && core_jump_addr_o == 16'h2000;
    endproperty
    a_boot: assert property (p_boot)
        else $error("application mode entered without the boot jump");

    c_int: cover property (core_jump_o && core_jump_addr_o == 16'h202b);
    c_boot: cover property ($rose(app_mode_o));
    c_ack: cover property (core_irq_req_o && core_irq_ack_i);
endmodule

bind mcuiv_top mcuiv_props mcuiv_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .core_irq_req_o(core_irq_req_o),
    .core_irq_ack_i(core_irq_ack_i), .core_jump_o(core_jump_o),
    .core_jump_addr_o(core_jump_addr_o), .app_mode_o(app_mode_o),
    .watchdog_timer_reset_i(watchdog_timer_reset_i)
);
`default_nettype wire

// ---- sim/mcuiv_top_bench.sv ----
// Purpose: Self-checking bench for the interrupt vectoring block.
// Assumes: mcuiv_core_model acks requests; the bench drives sources.
// Notes:   Sources pulse one cycle so an ack never re-requests.
`timescale 1ns/1ps
`default_nettype none
module mcuiv_top_bench;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [4:0]  adr_i;
    logic [3:0]  sel_i, core_wait;
    logic [31:0] dat_i, dat_o;
    logic        t0, t1, ser, krn, wdog, usb, done;
    logic [7:0]  isrc;
    logic        req, ack, jump, app, bad;
    logic [15:0] addr;
    int          num_errors, comparisons;

    mcuiv_top mcuiv_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .timer0_irq_i(t0),
        .timer1_irq_i(t1), .serial_irq_i(ser), .internal_src_i(isrc),
        .real_time_kernel_irq_i(krn), .watchdog_timer_reset_i(wdog),
        .usb_bus_reset_i(usb), .download_done_i(done),
        .core_irq_req_o(req), .core_irq_ack_i(ack), .core_jump_o(jump),
        .core_jump_addr_o(addr), .app_mode_o(app)
    );
    mcuiv_core_model mcuiv_core_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .wait_i(core_wait),
        .jump_i(jump), .addr_i(addr), .ack_o(ack), .bad_o(bad)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic pulse(input logic [4:0] m, input logic [7:0] ib);
        @(posedge clk_i);
        t0   <= m[0];
        t1   <= m[1];
        ser  <= m[2];
        isrc <= m[3] ? ib : 8'h00;
        krn  <= m[4];
        @(posedge clk_i);
        {t0, t1, ser, krn} <= 4'h0;
        isrc <= 8'h00;
    endtask

    task automatic wait_jump(input logic [15:0] e);
        int n = 0;
        while (jump !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0, jump, addr}, {16'h0001, e});
        @(posedge clk_i);
    endtask

    task automatic no_req;
        logic seen = 1'b0;
        repeat (40) begin
            @(posedge clk_i);
            if (req !== 1'b0) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0);
    endtask

    task automatic blip(input logic w);
        @(posedge clk_i);
        if (w) wdog <= 1'b1;
        else usb <= 1'b1;
        @(posedge clk_i);
        wdog <= 1'b0;
        usb  <= 1'b0;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_boot;
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h0);
        rd(5'h08, 32'h0);
        done <= 1'b1;
        wait_jump(16'h2000);
        @(posedge clk_i);
        chk({31'h0, app}, 32'h1);
        $display("boot done");
    endtask

    task automatic t_src;
        logic [15:0] vec [5] = '{16'h200b, 16'h201b, 16'h2023,
                                 16'h202b, 16'h2033};
        wr(5'h00, 8'hba);
        wr(5'h04, 8'h01);
        for (int i = 0; i < 5; i++) begin
            core_wait <= 4'(i);
            pulse(5'(1 << i), 8'h08);
            wait_jump(vec[i]);
        end
        $display("sources done");
    endtask

    task automatic t_gate;
        wr(5'h00, 8'h3a);
        pulse(5'h01, 8'h00);
        no_req();
        wr(5'h00, 8'hb8);
        no_req();
        wr(5'h00, 8'hba);
        wait_jump(16'h200b);
        wr(5'h04, 8'h00);
        pulse(5'h10, 8'h00);
        no_req();
        wr(5'h04, 8'h01);
        wait_jump(16'h2033);
        $display("gating done");
    endtask

    task automatic t_prio;
        core_wait <= 4'h8;
        pulse(5'h0c, 8'h01);
        wait_jump(16'h2023);
        wait_jump(16'h202b);
        wr(5'h08, 8'h20);
        pulse(5'h0c, 8'h80);
        wait_jump(16'h202b);
        wait_jump(16'h2023);
        wr(5'h0c, 8'h01);
        pulse(5'h11, 8'h00);
        wait_jump(16'h2033);
        wait_jump(16'h200b);
        rd(5'h18, 32'h200b);
        $display("priority done");
    endtask

    task automatic t_usb;
        wr(5'h10, 8'h00);
        blip(1'b0);
        rd(5'h00, 32'hba);
        wr(5'h10, 8'h01);
        blip(1'b0);
        rd(5'h00, 32'h0);
        rd(5'h08, 32'h0);
        rd(5'h0c, 32'h0);
        rd(5'h10, 32'h1);
        wr(5'h1c, 8'hff);
        rd(5'h1c, 32'h0);
        wr(5'h00, 8'hff);
        rd(5'h00, 32'hba);
        blip(1'b1);
        wait_jump(16'h2000);
        rd(5'h00, 32'h0);
        rd(5'h10, 32'h0);
        chk({31'h0, bad}, 32'h0);
        $display("resets done");
    endtask

    task automatic give_verdict;
        $display("comparisons=%0d errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The scenarios need under 2000 cycles; 20000 means a hang.
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, t0, t1, ser, krn} = 8'h80;
        {wdog, usb, done} = 3'h0;
        adr_i = 5'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        isrc = 8'h00;
        core_wait = 4'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_src();
        t_gate();
        t_prio();
        t_usb();
        give_verdict();
    end
endmodule
`default_nettype wire
